//--- src/dmee_top.sv
// Dual-mode memory: streaming on the transmit-only clock, mode control on the bus
// Behaviour
// - Power up streaming, pointer at location zero
// - Streaming uses link clock; bus uses bus clock
// - Eight data bits then one null bit
// - New bit on each link clock rising edge
// - Most significant bit first
// - Ascending addresses, wrap to zero seamlessly
// - Bus clock fall enters transition state
// - Own control byte seen: stay bidirectional
// - No control byte: fall back after 128 pulses
// - Nine sync edges released, data on tenth
// - Control byte upper seven bits 1010000
// - Bus clock fall clears the pulse counter
// - Fallback restarts at location zero, MSB first
`timescale 1ns/100ps
`default_nettype none
module dmee_top
    import dmee_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_tx_only_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_wr_en,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [BYTE_W-1:0] i_wr_data,
    output logic [1:0] o_mode,
    output logic o_ctrl_rw
);

    ////////////////////////////////////////////////////////////////////////
    // System-domain declarations

    dmee_mode_t mode_reg;
    dmee_det_t det_reg;
    logic [BYTE_W-1:0] mem_reg [MEM_DEPTH];
    logic [1:0] pin_q;
    logic [1:0] lnk_q;
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_fall;
    logic scl_rise;
    logic start_cond;
    logic stop_cond;
    logic pulse_seen_reg;
    logic pulse_evt;
    logic [7:0] pulse_cnt_reg;
    logic fallback;
    logic [6:0] det_sh_reg;
    logic [2:0] det_cnt_reg;
    logic ctrl_hit;
    logic [ADDR_W-1:0] fill_ptr_reg;
    logic [BYTE_W-1:0] xfer_data_reg;
    logic xfer_tgl_reg;
    logic ce_mirror_reg;
    logic stream_en_reg;
    logic send_free;

    dmee_fifo_if #(.W(BYTE_W)) fq ();

    ////////////////////////////////////////////////////////////////////////
    // Link-domain declarations

    logic lrst_q;
    logic [2:0] lsync_q;
    logic link_rst_n;
    logic tgl_l;
    logic stream_l;
    logic ce_l;
    logic l_tgl_seen_reg;
    logic ack_tgl_reg;
    logic pulse_tgl_reg;
    logic [BYTE_W-1:0] nxt_buf_reg;
    logic nxt_full_reg;
    logic [BYTE_W-1:0] sh_reg;
    logic [3:0] bit_pos_reg;
    logic [3:0] init_cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin and cross-domain synchronisers into the system clock

    dmee_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
        .i_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_en(i_ce),
        .i_d({i_scl, i_sda}),
        .o_q(pin_q)
    );

    dmee_sync #(.W(2), .INIT(2'h0)) u_lnk_sync (
        .i_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_en(i_ce),
        .i_d({pulse_tgl_reg, ack_tgl_reg}),
        .o_q(lnk_q)
    );

    assign scl_s = pin_q[1];
    assign sda_s = pin_q[0];
    assign scl_fall = scl_d_reg && !scl_s;
    assign scl_rise = !scl_d_reg && scl_s;
    assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    assign pulse_evt = lnk_q[1] ^ pulse_seen_reg;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            pulse_seen_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            pulse_seen_reg <= lnk_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode control

    // Counting the pulse that completes the 128 while no bus clock fall lands
    assign fallback = (mode_reg == MODE_TRANS) && pulse_evt && !scl_fall &&
                      (pulse_cnt_reg == FALLBACK_PULSES - 8'h01);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            mode_reg <= MODE_STREAM;
        end
        else if (i_ce)
        begin
            case (mode_reg)
                MODE_STREAM:
                begin
                    // A stuck-low bus clock gives a single fall, so fallback still returns to streaming
                    if (scl_fall)
                    begin
                        mode_reg <= MODE_TRANS;
                    end
                end
                MODE_TRANS:
                begin
                    if (ctrl_hit)
                    begin
                        mode_reg <= MODE_BIDIR;
                    end
                    else if (fallback)
                    begin
                        mode_reg <= MODE_STREAM;
                    end
                end
                MODE_BIDIR:
                begin
                    // Only a reset leaves bidirectional mode
                    mode_reg <= MODE_BIDIR;
                end
                default:
                begin
                    mode_reg <= MODE_STREAM;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            pulse_cnt_reg <= 8'h00;
        end
        else if (i_ce)
        begin
            if (mode_reg != MODE_TRANS || scl_fall)
            begin
                pulse_cnt_reg <= 8'h00;
            end
            else if (pulse_evt)
            begin
                pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control byte watcher during the transition state

    assign ctrl_hit = (mode_reg == MODE_TRANS) && (det_reg == DET_SHIFT) && scl_rise &&
                      (det_cnt_reg == CTRL_LAST_BIT) && (det_sh_reg == CTRL_DEV_CODE);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            det_reg <= DET_IDLE;
            det_sh_reg <= 7'h00;
            det_cnt_reg <= 3'h0;
            o_ctrl_rw <= 1'b0;
        end
        else if (i_ce)
        begin
            if (mode_reg != MODE_TRANS || stop_cond)
            begin
                det_reg <= DET_IDLE;
            end
            else if (start_cond)
            begin
                det_reg <= DET_SHIFT;
                det_cnt_reg <= 3'h0;
            end
            else
            begin
                case (det_reg)
                    DET_IDLE:
                    begin
                        det_reg <= DET_IDLE;
                    end
                    DET_SHIFT:
                    begin
                        if (scl_rise)
                        begin
                            det_sh_reg <= {det_sh_reg[5:0], sda_s};
                            det_cnt_reg <= det_cnt_reg + 3'h1;
                            if (det_cnt_reg == CTRL_LAST_BIT)
                            begin
                                det_reg <= DET_DONE;
                                o_ctrl_rw <= sda_s;
                            end
                        end
                    end
                    DET_DONE:
                    begin
                        det_reg <= DET_DONE;
                    end
                    default:
                    begin
                        det_reg <= DET_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage array and in-order byte fetch into the FIFO

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < MEM_DEPTH; i++)
            begin
                mem_reg[i] <= MEM_RESET_VALUE;
            end
        end
        else if (i_ce && i_wr_en)
        begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
    end

    assign fq.wr_valid = (mode_reg == MODE_STREAM);
    assign fq.wr_data = mem_reg[fill_ptr_reg];
    // Stale prefetched bytes are dropped so fallback restarts cleanly
    assign fq.flush = (mode_reg == MODE_STREAM) && scl_fall;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            fill_ptr_reg <= START_ADDR;
        end
        else if (i_ce)
        begin
            if (fallback || fq.flush)
            begin
                fill_ptr_reg <= START_ADDR;
            end
            else if (fq.wr_valid && fq.wr_ready)
            begin
                // Natural 7-bit wrap after the top location
                fill_ptr_reg <= fill_ptr_reg + 7'h01;
            end
        end
    end

    dmee_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .i_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .f(fq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Handshake sender towards the link domain

    assign send_free = (lnk_q[0] == xfer_tgl_reg);
    assign fq.rd_ready = send_free && (mode_reg == MODE_STREAM);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            xfer_data_reg <= 8'h00;
            xfer_tgl_reg <= 1'b0;
            stream_en_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            stream_en_reg <= (mode_reg == MODE_STREAM);
            if (fq.rd_valid && fq.rd_ready)
            begin
                xfer_data_reg <= fq.rd_data;
                xfer_tgl_reg <= !xfer_tgl_reg;
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            ce_mirror_reg <= 1'b0;
            o_mode <= MODE_STREAM;
        end
        else
        begin
            ce_mirror_reg <= i_ce;
            if (i_ce)
            begin
                o_mode <= mode_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: streaming on the transmit-only clock

    dmee_sync #(.W(1), .INIT(1'b0)) u_lrst_sync (
        .i_clk(i_tx_only_clk),
        .i_rst_n(1'b1),
        .i_en(1'b1),
        .i_d(i_rst_n),
        .o_q(lrst_q)
    );

    assign link_rst_n = lrst_q;

    dmee_sync #(.W(3), .INIT(3'h0)) u_lctl_sync (
        .i_clk(i_tx_only_clk),
        .i_rst_n(link_rst_n),
        .i_en(1'b1),
        .i_d({xfer_tgl_reg, stream_en_reg, ce_mirror_reg}),
        .o_q(lsync_q)
    );

    assign tgl_l = lsync_q[2];
    assign stream_l = lsync_q[1];
    assign ce_l = lsync_q[0];

    // Every rising edge while the mirrored enable is high is reported, so the count runs in the system domain
    always_ff @(posedge i_tx_only_clk)
    begin
        if (!link_rst_n)
        begin
            pulse_tgl_reg <= 1'b0;
        end
        else if (ce_l)
        begin
            pulse_tgl_reg <= !pulse_tgl_reg;
        end
    end

    always_ff @(posedge i_tx_only_clk)
    begin
        if (!link_rst_n)
        begin
            init_cnt_reg <= 4'h0;
        end
        else if (ce_l && init_cnt_reg != INIT_EDGES)
        begin
            init_cnt_reg <= init_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge i_tx_only_clk)
    begin
        if (!link_rst_n)
        begin
            l_tgl_seen_reg <= 1'b0;
            ack_tgl_reg <= 1'b0;
            nxt_buf_reg <= 8'h00;
            nxt_full_reg <= 1'b0;
            sh_reg <= 8'h00;
            bit_pos_reg <= FRAME_LOAD_POS;
            o_sda_o <= 1'b1;
            o_sda_oe <= 1'b0;
        end
        else if (ce_l)
        begin
            // Data register is stable: the sender waits for our acknowledge
            if (tgl_l != l_tgl_seen_reg)
            begin
                nxt_buf_reg <= xfer_data_reg;
                nxt_full_reg <= 1'b1;
                l_tgl_seen_reg <= tgl_l;
            end
            if (init_cnt_reg != INIT_EDGES)
            begin
                o_sda_oe <= 1'b0;
            end
            else if (!stream_l)
            begin
                o_sda_oe <= 1'b0;
                bit_pos_reg <= FRAME_LOAD_POS;
                if (nxt_full_reg)
                begin
                    nxt_full_reg <= 1'b0;
                    ack_tgl_reg <= l_tgl_seen_reg;
                end
            end
            else if (bit_pos_reg == FRAME_LOAD_POS)
            begin
                // Underrun leaves the line released rather than sending junk
                if (nxt_full_reg)
                begin
                    o_sda_o <= nxt_buf_reg[BYTE_W-1];
                    o_sda_oe <= 1'b1;
                    sh_reg <= {nxt_buf_reg[BYTE_W-2:0], 1'b0};
                    nxt_full_reg <= 1'b0;
                    ack_tgl_reg <= l_tgl_seen_reg;
                    bit_pos_reg <= 4'h2;
                end
                else
                begin
                    o_sda_oe <= 1'b0;
                end
            end
            else if (bit_pos_reg != FRAME_NULL_POS)
            begin
                o_sda_o <= sh_reg[BYTE_W-1];
                sh_reg <= {sh_reg[BYTE_W-2:0], 1'b0};
                bit_pos_reg <= bit_pos_reg + 4'h1;
            end
            else
            begin
                o_sda_o <= 1'b1;
                bit_pos_reg <= FRAME_LOAD_POS;
            end
        end
    end

endmodule
`default_nettype wire

//--- common/dmee_pkg.sv
// Shared constants and types for the dual-mode streaming memory block
package dmee_pkg;

    localparam int MEM_DEPTH = 128;
    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 32;

    // Streamed frame: data bits at positions 0 and 2..8, null bit at position 9
    localparam logic [3:0] FRAME_NULL_POS = 4'h9;
    localparam logic [3:0] FRAME_LOAD_POS = 4'h0;
    // Link edges spent on synchronisation before the first data bit
    localparam logic [3:0] INIT_EDGES = 4'h9;
    // Idle link pulses in the transition state before falling back
    localparam logic [7:0] FALLBACK_PULSES = 8'h80;
    localparam logic [ADDR_W-1:0] START_ADDR = 7'h00;
    localparam logic [6:0] CTRL_DEV_CODE = 7'h50;
    localparam logic [2:0] CTRL_LAST_BIT = 3'h7;
    localparam logic [BYTE_W-1:0] MEM_RESET_VALUE = 8'h00;

    typedef enum logic [1:0] {
        MODE_STREAM = 2'b00,
        MODE_TRANS = 2'b01,
        MODE_BIDIR = 2'b10
    } dmee_mode_t;

    typedef enum logic [1:0] {
        DET_IDLE = 2'b00,
        DET_SHIFT = 2'b01,
        DET_DONE = 2'b10
    } dmee_det_t;

endpackage

//--- common/dmee_fifo_if.sv
// Carrier between the byte fetcher, the FIFO and the link sender
`timescale 1ns/100ps
`default_nettype none
interface dmee_fifo_if #(parameter int W = 8);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    logic flush;

    modport fifo (
        input wr_valid, wr_data, rd_ready, flush,
        output wr_ready, rd_valid, rd_data
    );
    modport user (
        output wr_valid, wr_data, rd_ready, flush,
        input wr_ready, rd_valid, rd_data
    );
endinterface
`default_nettype wire

//--- src/dmee_sync.sv
// Three-stage synchroniser, output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module dmee_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            o_q <= INIT;
        end
        else if (i_en)
        begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++)
            begin
                if (s2_reg[i] == s3_reg[i])
                begin
                    o_q[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- src/dmee_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/100ps
`default_nettype none
module dmee_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    dmee_fifo_if.fifo f
);
    localparam int PW = $clog2(D);

    logic [W-1:0] mem_reg [D];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign f.wr_ready = (count_reg != (PW + 1)'(D));
    assign f.rd_valid = (count_reg != '0);
    assign f.rd_data = mem_reg[rd_ptr_reg];
    assign push = f.wr_valid && f.wr_ready;
    assign pop = f.rd_valid && f.rd_ready;

    always_ff @(posedge i_clk)
    begin
        if (i_ce && push)
        begin
            mem_reg[wr_ptr_reg] <= f.wr_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else if (i_ce)
        begin
            if (f.flush)
            begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                count_reg <= '0;
            end
            else
            begin
                if (push)
                begin
                    wr_ptr_reg <= (wr_ptr_reg == PW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
                end
                if (pop)
                begin
                    rd_ptr_reg <= (rd_ptr_reg == PW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
                end
                count_reg <= count_reg + (PW + 1)'(push) - (PW + 1)'(pop);
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/dmee_top_asserts.sv
// Pin-level assertions for the dual-mode streaming memory
`timescale 1ns/100ps
`default_nettype none
module dmee_top_asserts
    import dmee_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_only_clk,
    input wire logic i_scl,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic [1:0] o_mode,
    input wire logic o_ctrl_rw
);
////////////////////////////////////////////////////////////////////////////////
logic [3:0] pos_reg;
logic [9:0] idle_reg;
// Bits already sent in the current frame; a released line restarts it
always_ff @(posedge i_tx_only_clk)
begin
    if (!o_sda_oe || pos_reg == 4'h8)
        pos_reg <= 4'h0;
    else
        pos_reg <= pos_reg + 4'h1;
end
// Quiet-bus cycles in transition; 128 pulses at the bench rate need about 400
always_ff @(posedge i_sys_clk)
begin
    if (!i_rst_n || !i_scl || o_mode != MODE_TRANS)
        idle_reg <= 10'h000;
    else if (idle_reg != 10'h3FF)
        idle_reg <= idle_reg + 10'h001;
end
////////////////////////////////////////////////////////////////////////////////
sequence s_fallback;
    o_mode == MODE_TRANS ##1 o_mode == MODE_STREAM;
endsequence
sequence s_link_edge;
    $rose(i_tx_only_clk);
endsequence
chk_reset_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> o_mode == MODE_STREAM && !o_ctrl_rw && !o_sda_oe)
    else $error("state after reset wrong");
chk_stream_exit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_mode == MODE_STREAM |=> o_mode inside {MODE_STREAM, MODE_TRANS})
    else $error("streaming left to a wrong mode");
chk_fall_enters: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(i_scl) && o_mode == MODE_STREAM |-> ##[1:10] o_mode == MODE_TRANS)
    else $error("bus clock fall did not start transition");
chk_bidir_stays: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_mode == MODE_BIDIR |=> o_mode == MODE_BIDIR)
    else $error("bidirectional mode was left");
chk_fallback_wait: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_fallback |-> idle_reg >= 10'h172)
    else $error("fallback before enough quiet pulses");
chk_rw_trans: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $changed(o_ctrl_rw) |-> o_mode != MODE_STREAM)
    else $error("direction bit changed while streaming");
chk_link_timed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $changed(o_sda_oe) || $changed(o_sda_o) |-> s_link_edge)
    else $error("data line moved without a link edge");
chk_oe_release: assert property (@(posedge i_tx_only_clk) disable iff (!i_rst_n)
    (o_mode != MODE_STREAM) [*8] |-> !o_sda_oe)
    else $error("data line driven outside streaming");
chk_null_bit: assert property (@(posedge i_tx_only_clk) disable iff (!i_rst_n)
    o_sda_oe && pos_reg == 4'h8 |-> o_sda_o)
    else $error("ninth bit not high");
endmodule
`default_nettype wire

//--- verification/dmee_host_model.sv
// Host-side model: transmit-only clock source and bus master
`timescale 1ns/100ps
`default_nettype none
module dmee_host_model (
    input wire logic i_sda_o,
    input wire logic i_sda_oe,
    output logic o_link_clk,
    output logic o_scl,
    output logic o_sda_drv,
    output logic o_seen_oe,
    output logic o_seen_bit
);
////////////////////////////////////////////////////////////////////////////////
// Clock stands low between bursts
initial
begin
    o_link_clk = 1'b0;
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
    o_seen_oe = 1'b0;
    o_seen_bit = 1'b0;
end
// Samples the line well after the rising edge that launched the bit
task automatic pulse(input int n);
    repeat (n)
    begin
        #62.5 o_link_clk = 1'b1;
        #20 o_seen_oe = i_sda_oe;
        o_seen_bit = i_sda_o;
        #42.5 o_link_clk = 1'b0;
    end
endtask
// Each level holds ten system cycles so the synchronisers settle
task automatic set_bus(input logic c, input logic d);
    o_scl = c;
    o_sda_drv = d;
    #400;
endtask
// START, eight bits MSB first, STOP; data moves only while the clock is low
task automatic send_byte(input logic [7:0] b);
    set_bus(1'b1, 1'b1);
    set_bus(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--)
    begin
        set_bus(1'b0, o_sda_drv);
        set_bus(1'b0, b[i]);
        set_bus(1'b1, b[i]);
    end
    set_bus(1'b0, o_sda_drv);
    set_bus(1'b0, 1'b0);
    set_bus(1'b1, 1'b0);
    set_bus(1'b1, 1'b1);
endtask
endmodule
`default_nettype wire

//--- verification/tb_dmee_top.sv
// Self-checking bench for the dual-mode streaming memory
`timescale 1ns/100ps
`default_nettype none
module tb_dmee_top
    import dmee_pkg::*;
;
logic i_sys_clk = 1'b0;
logic i_rst_n = 1'b0;
logic ce = 1'b1;
logic wr_en = 1'b0;
logic [6:0] wr_addr = 7'h00;
logic [7:0] wr_data = 8'h00;
wire link_clk, scl, sda_drv, sda_o, sda_oe, seen_oe, seen_bit, ctrl_rw, sda_line;
wire [1:0] mode;
int num_errors = 0;
int compares = 0;
logic [7:0] mem_exp [128];
always #20 i_sys_clk = ~i_sys_clk;
// Push-pull while enabled, otherwise host open drain with pull-up
assign sda_line = sda_oe ? sda_o : sda_drv;
dmee_top u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_tx_only_clk(link_clk),
    .i_scl(scl), .i_sda(sda_line), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_wr_en(wr_en),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_mode(mode), .o_ctrl_rw(ctrl_rw)
);
dmee_host_model u_host (
    .i_sda_o(sda_o), .i_sda_oe(sda_oe), .o_link_clk(link_clk), .o_scl(scl),
    .o_sda_drv(sda_drv), .o_seen_oe(seen_oe), .o_seen_bit(seen_bit)
);
////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
        num_errors++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic check_mode(input logic [1:0] m);
    repeat (10) @(negedge i_sys_clk);
    check({6'h00, mode}, {6'h00, m});
endtask
task automatic stop_test;
    if (num_errors == 0 && compares > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
// Link edges must run during reset so the link side resets too
task automatic do_reset;
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    u_host.pulse(8);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
endtask
task automatic enter_trans;
    u_host.set_bus(1'b0, 1'b1);
    u_host.set_bus(1'b1, 1'b1);
endtask
// k returns the released edges before the first driven bit
task automatic check_stream(input int n, input logic zero, output int k);
    logic [7:0] b;
    k = 0;
    u_host.pulse(1);
    while (seen_oe !== 1'b1 && k < 40)
    begin
        u_host.pulse(1);
        k++;
    end
    for (int a = 0; a < n; a++)
    begin
        b = zero ? 8'h00 : mem_exp[a % 128];
        for (int i = 7; i >= 0; i--)
        begin
            check({6'h00, seen_oe, seen_bit}, {6'h00, 1'b1, b[i]});
            u_host.pulse(1);
        end
        check({6'h00, seen_oe, seen_bit}, 8'h03);
        u_host.pulse(1);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_power_up;
    int k;
    check_mode(MODE_STREAM);
    check_stream(2, 1'b1, k);
    // Link reset and control synchronisers hold the count off for eight edges
    check(8'(k), 8'(INIT_EDGES) + 8'h08);
endtask
task automatic t_fill;
    logic [7:0] b;
    for (int a = 0; a < 128; a++)
    begin
        b = (a[7:0] * 8'h1D) ^ 8'h5A;
        mem_exp[a] = b;
        @(posedge i_sys_clk);
        wr_en <= 1'b1;
        wr_addr <= a[6:0];
        wr_data <= b;
    end
    @(posedge i_sys_clk);
    wr_en <= 1'b0;
endtask
task automatic t_fallback;
    int k;
    enter_trans();
    check_mode(MODE_TRANS);
    u_host.pulse(8);
    check({7'h00, seen_oe}, 8'h00);
    u_host.pulse(118);
    check_mode(MODE_TRANS);
    u_host.pulse(4);
    check_mode(MODE_STREAM);
    check_stream(130, 1'b0, k);
endtask
task automatic t_clear;
    enter_trans();
    u_host.pulse(100);
    enter_trans();
    u_host.pulse(100);
    check_mode(MODE_TRANS);
    u_host.pulse(40);
    check_mode(MODE_STREAM);
endtask
// Clock enable low must freeze the pulse count, so 300 pulses do not fall back
task automatic t_freeze;
    enter_trans();
    u_host.pulse(8);
    @(posedge i_sys_clk);
    ce <= 1'b0;
    u_host.pulse(200);
    check_mode(MODE_TRANS);
    @(posedge i_sys_clk);
    ce <= 1'b1;
    u_host.pulse(100);
    check_mode(MODE_TRANS);
    u_host.pulse(30);
    check_mode(MODE_STREAM);
endtask
task automatic t_control;
    enter_trans();
    u_host.pulse(8);
    u_host.send_byte(8'hA2);
    check_mode(MODE_TRANS);
    u_host.send_byte(8'hA1);
    check_mode(MODE_BIDIR);
    check({7'h00, ctrl_rw}, 8'h01);
    u_host.pulse(200);
    check_mode(MODE_BIDIR);
    check({7'h00, seen_oe}, 8'h00);
endtask
task automatic t_reset_again;
    do_reset();
    check_mode(MODE_STREAM);
    check({7'h00, ctrl_rw}, 8'h00);
    enter_trans();
    u_host.pulse(8);
    u_host.send_byte(8'hA0);
    check_mode(MODE_BIDIR);
    check({7'h00, ctrl_rw}, 8'h00);
endtask
initial
begin
    do_reset();
    t_power_up();
    t_fill();
    t_fallback();
    t_clear();
    t_freeze();
    t_control();
    t_reset_again();
    stop_test();
end
initial
begin
    #3000000;
    num_errors++;
    stop_test();
end
endmodule
bind dmee_top dmee_top_asserts u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_tx_only_clk(i_tx_only_clk),
    .i_scl(i_scl), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_mode(o_mode),
    .o_ctrl_rw(o_ctrl_rw)
);
`default_nettype wire
